// ---- shared/profiler_pkg.sv ----
// constants and types shared by the independent axis profiler
package profiler_pkg;
    // structure
    localparam int AXES = 4;
    localparam int AXIS_W = 2;
    localparam int POS_W = 32;
    localparam int VEL_W = 24;
    localparam int RATE_W = 16;
    localparam int SMOOTH_W = 5;
    localparam int DATA_W = 32;
    localparam int HADDR_W = 32;
    localparam int ADDR_W = 12;
    localparam int BRK_W = 64;

    // timing: one trajectory update per sample period
    localparam int CLK_MHZ = 250;
    localparam int SAMPLE_NS = 1000;
    localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int TICK_W = 8;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYC - 1);
    localparam logic [TICK_W-1:0] TICK_RST = 8'h00;

    // ahb-lite
    localparam int HTRANS_ACT_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // register map: global page
    localparam logic [ADDR_W-1:0] CMD_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
    // register map: per-axis page, axis a at AXIS page + a * 0x20
    localparam int AXIS_PAGE_LSB = 7;
    localparam logic [ADDR_W-AXIS_PAGE_LSB-1:0] AXIS_PAGE = 5'h02;
    localparam int AXIS_LSB = 5;
    localparam logic [AXIS_LSB-1:0] ABS_OFS = 5'h00;
    localparam logic [AXIS_LSB-1:0] REL_OFS = 5'h04;
    localparam logic [AXIS_LSB-1:0] SLEW_OFS = 5'h08;
    localparam logic [AXIS_LSB-1:0] UP_OFS = 5'h0C;
    localparam logic [AXIS_LSB-1:0] DN_OFS = 5'h10;
    localparam logic [AXIS_LSB-1:0] SMOOTH_OFS = 5'h14;
    localparam logic [AXIS_LSB-1:0] INC_OFS = 5'h18;
    localparam logic [AXIS_LSB-1:0] POS_OFS = 5'h1C;

    // command word fields
    localparam int CMD_MASK_LSB = 0;
    localparam int CMD_OP_LSB = 8;
    localparam int OP_W = 2;
    localparam logic [OP_W-1:0] OP_LAUNCH = 2'h1;
    localparam logic [OP_W-1:0] OP_HALT = 2'h2;
    // status word fields
    localparam int STAT_DONE_LSB = 0;
    localparam int STAT_INPOS_LSB = 8;

    // reset and fixed values
    localparam logic [POS_W-1:0] POS_RST = 32'h00000000;
    localparam logic [POS_W-1:0] POS_ONE = 32'h00000001;
    localparam logic [POS_W-1:0] POS_NEG_ONE = 32'hFFFFFFFF;
    localparam logic [VEL_W-1:0] VEL_ZERO = 24'h000000;
    localparam logic [VEL_W-1:0] VEL_MIN = 24'h000001;
    localparam logic [RATE_W-1:0] RATE_RST = 16'h0000;
    localparam logic [SMOOTH_W-1:0] SMOOTH_RST = 5'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

    typedef logic signed [POS_W-1:0] pos_t;

    typedef enum logic [3:0] {
        AX_IDLE = 4'b0001,
        AX_RUN = 4'b0010,
        AX_HALT = 4'b0100,
        AX_SETTLE = 4'b1000
    } axis_state_t;
endpackage

// ---- src/independent_axis_profiler.sv ----
// independent point-to-point trajectory profiler with ahb-lite registers
// Contract
// - each axis runs its own independent profile
// - launch builds trapezoid or triangle toward target
// - new commanded position every sample period
// - reach slew, cruise, ramp down, stop exactly
// - short move ramps down early, triangular
// - done once final position is issued
// - next command accepted right after done
// - launch any axis subset together or separately
// - launch naming no axis starts all
// - slew and ramp-up change live
// - ramp-down and target locked while moving
// - halt ramps axis down before target
// - increment adds to target, regenerates profile
// - increment needs no separate launch
// - increment at rest is relative move plus launch
// - profile-done and in-position wait conditions
// - per-axis smoothing time constant
// - destination readback: target moving, else position
// - readback ramp rates, slew, relative distance
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module independent_axis_profiler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [profiler_pkg::HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [profiler_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [profiler_pkg::DATA_W-1:0] hrdata,
    // axis side
    input wire logic [profiler_pkg::AXES-1:0] in_position_pin,
    output logic [profiler_pkg::AXES-1:0][profiler_pkg::POS_W-1:0] cmd_position,
    output logic [profiler_pkg::AXES-1:0] profile_done,
    output logic [profiler_pkg::AXES-1:0] in_position_ok,
    output logic sample_tick
);
    import profiler_pkg::*;

    function automatic logic axis_hit(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:AXIS_PAGE_LSB] == AXIS_PAGE;
    endfunction

    function automatic logic [AXIS_W-1:0] axis_of(input logic [ADDR_W-1:0] a);
        return a[AXIS_LSB +: AXIS_W];
    endfunction

    function automatic logic brake_needed(input logic [VEL_W-1:0] v,
                                          input logic [RATE_W-1:0] dn,
                                          input logic [POS_W:0] rem);
        logic [BRK_W-1:0] lhs;
        logic [BRK_W-1:0] rhs;
        lhs = BRK_W'(v) * BRK_W'(v);
        rhs = (BRK_W'(dn) * BRK_W'(rem)) << 1;
        return lhs >= rhs;
    endfunction

    // bus phase registers
    logic dp_wr_q;
    logic [ADDR_W-1:0] dp_addr_q;
    logic [DATA_W-1:0] rd_d;
    logic [DATA_W-1:0] rd_q;
    logic ap_valid;

    // per-axis state
    axis_state_t st_q [AXES];
    pos_t tgt_q [AXES];
    pos_t gen_q [AXES];
    pos_t out_q [AXES];
    pos_t abs_q [AXES];
    pos_t rel_q [AXES];
    logic abs_mode_q [AXES];
    logic [VEL_W-1:0] vel_q [AXES];
    logic [VEL_W-1:0] slew_q [AXES];
    logic [RATE_W-1:0] up_q [AXES];
    logic [RATE_W-1:0] dn_q [AXES];
    logic [SMOOTH_W-1:0] smooth_q [AXES];

    // trajectory next values
    logic signed [POS_W:0] rem_s [AXES];
    logic [POS_W:0] rem_m [AXES];
    logic [POS_W:0] step [AXES];
    logic [VEL_W:0] vsum [AXES];
    logic [VEL_W-1:0] vel_n [AXES];
    logic dir [AXES];
    logic brake [AXES];
    logic gen_end [AXES];
    pos_t gen_n [AXES];
    pos_t fdiff [AXES];
    pos_t fstep [AXES];
    pos_t out_n [AXES];

    // decoded writes
    logic cmd_wr;
    logic [OP_W-1:0] cmd_op;
    logic [AXES-1:0] cmd_mask;
    logic [AXES-1:0] launch_cmd;
    logic [AXES-1:0] halt_cmd;
    logic [AXES-1:0] abs_wr, rel_wr, slew_wr, up_wr, dn_wr, smooth_wr, inc_wr;

    logic [TICK_W-1:0] tick_cnt_q;
    logic tick_q;
    logic [AXES-1:0] inpos_m_q;
    logic [AXES-1:0] inpos_s_q;

    // ahb-lite: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = rd_q;
    assign ap_valid = hsel && hready && htrans[HTRANS_ACT_BIT];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= CMD_OFS;
        end else begin
            dp_wr_q <= ap_valid && hwrite && (hsize == HSIZE_WORD);
            dp_addr_q <= haddr[ADDR_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_q <= DATA_ZERO;
        end else if (ap_valid && !hwrite) begin
            rd_q <= rd_d;
        end
    end

    // read mux, looked up in the address phase
    always_comb begin
        rd_d = DATA_ZERO;
        if (haddr[ADDR_W-1:0] == STATUS_OFS) begin
            rd_d[STAT_DONE_LSB +: AXES] = profile_done;
            rd_d[STAT_INPOS_LSB +: AXES] = in_position_ok;
        end else if (axis_hit(haddr[ADDR_W-1:0])) begin
            for (int a = 0; a < AXES; a++) begin
                if (axis_of(haddr[ADDR_W-1:0]) == AXIS_W'(a)) begin
                    case (haddr[AXIS_LSB-1:0])
                        ABS_OFS: rd_d = (st_q[a] != AX_IDLE) ? tgt_q[a] : out_q[a];
                        REL_OFS: rd_d = rel_q[a];
                        SLEW_OFS: rd_d = DATA_W'(slew_q[a]);
                        UP_OFS: rd_d = DATA_W'(up_q[a]);
                        DN_OFS: rd_d = DATA_W'(dn_q[a]);
                        SMOOTH_OFS: rd_d = DATA_W'(smooth_q[a]);
                        POS_OFS: rd_d = out_q[a];
                        default: rd_d = DATA_ZERO;
                    endcase
                end
            end
        end
    end

    // write decode in the data phase
    always_comb begin
        cmd_wr = dp_wr_q && (dp_addr_q == CMD_OFS);
        cmd_op = hwdata[CMD_OP_LSB +: OP_W];
        cmd_mask = hwdata[CMD_MASK_LSB +: AXES];
        launch_cmd = '0;
        halt_cmd = '0;
        // any subset, empty mask means all
        if (cmd_wr && cmd_op == OP_LAUNCH) begin
            launch_cmd = (cmd_mask == '0) ? '1 : cmd_mask;
        end
        if (cmd_wr && cmd_op == OP_HALT) begin
            halt_cmd = (cmd_mask == '0) ? '1 : cmd_mask;
        end
        for (int a = 0; a < AXES; a++) begin
            abs_wr[a] = 1'b0;
            rel_wr[a] = 1'b0;
            slew_wr[a] = 1'b0;
            up_wr[a] = 1'b0;
            dn_wr[a] = 1'b0;
            smooth_wr[a] = 1'b0;
            inc_wr[a] = 1'b0;
            if (dp_wr_q && axis_hit(dp_addr_q) && axis_of(dp_addr_q) == AXIS_W'(a)) begin
                abs_wr[a] = dp_addr_q[AXIS_LSB-1:0] == ABS_OFS;
                rel_wr[a] = dp_addr_q[AXIS_LSB-1:0] == REL_OFS;
                slew_wr[a] = dp_addr_q[AXIS_LSB-1:0] == SLEW_OFS;
                up_wr[a] = dp_addr_q[AXIS_LSB-1:0] == UP_OFS;
                dn_wr[a] = dp_addr_q[AXIS_LSB-1:0] == DN_OFS;
                smooth_wr[a] = dp_addr_q[AXIS_LSB-1:0] == SMOOTH_OFS;
                inc_wr[a] = dp_addr_q[AXIS_LSB-1:0] == INC_OFS;
            end
        end
    end

    // sample period tick
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_cnt_q <= TICK_RST;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? TICK_RST : tick_cnt_q + 1'b1;
        end
    end
    assign sample_tick = tick_q;

    // in-position pins cross into the clock domain
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            inpos_m_q <= '0;
            inpos_s_q <= '0;
        end else begin
            inpos_m_q <= in_position_pin;
            inpos_s_q <= inpos_m_q;
        end
    end

    // parameter registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int a = 0; a < AXES; a++) begin
                abs_q[a] <= POS_RST;
                rel_q[a] <= POS_RST;
                abs_mode_q[a] <= 1'b0;
                slew_q[a] <= VEL_ZERO;
                up_q[a] <= RATE_RST;
                dn_q[a] <= RATE_RST;
                smooth_q[a] <= SMOOTH_RST;
            end
        end else begin
            for (int a = 0; a < AXES; a++) begin
                if (slew_wr[a]) slew_q[a] <= hwdata[VEL_W-1:0];
                if (up_wr[a]) up_q[a] <= hwdata[RATE_W-1:0];
                if (smooth_wr[a]) smooth_q[a] <= hwdata[SMOOTH_W-1:0];
                if (st_q[a] == AX_IDLE) begin
                    if (dn_wr[a]) dn_q[a] <= hwdata[RATE_W-1:0];
                    if (abs_wr[a]) begin
                        abs_q[a] <= pos_t'(hwdata);
                        abs_mode_q[a] <= 1'b1;
                    end
                    // increment at rest also sets relative distance
                    if (rel_wr[a] || inc_wr[a]) begin
                        rel_q[a] <= pos_t'(hwdata);
                        abs_mode_q[a] <= 1'b0;
                    end
                end
            end
        end
    end

    // trajectory step, one per axis
    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            rem_s[a] = {tgt_q[a][POS_W-1], tgt_q[a]} - {gen_q[a][POS_W-1], gen_q[a]};
            dir[a] = rem_s[a][POS_W];
            rem_m[a] = dir[a] ? (POS_W+1)'(-rem_s[a]) : (POS_W+1)'(rem_s[a]);
            brake[a] = brake_needed(vel_q[a], dn_q[a], rem_m[a]);
            vsum[a] = {1'b0, vel_q[a]} + (VEL_W+1)'(up_q[a]);
            if (st_q[a] == AX_HALT || brake[a]) begin
                // ramp down at the ramp-down rate
                vel_n[a] = (vel_q[a] > VEL_W'(dn_q[a])) ? vel_q[a] - VEL_W'(dn_q[a]) : VEL_ZERO;
                if (st_q[a] != AX_HALT && vel_n[a] == VEL_ZERO) begin
                    vel_n[a] = VEL_MIN;
                end
            end else if (vel_q[a] < slew_q[a]) begin
                // ramp up, then cruise at slew
                vel_n[a] = (vsum[a] > {1'b0, slew_q[a]}) ? slew_q[a] : vsum[a][VEL_W-1:0];
            end else if (vel_q[a] > slew_q[a]) begin
                vel_n[a] = (vel_q[a] - slew_q[a] > VEL_W'(up_q[a])) ?
                           vel_q[a] - VEL_W'(up_q[a]) : slew_q[a];
            end else begin
                vel_n[a] = vel_q[a];
            end
            step[a] = ((POS_W+1)'(vel_n[a]) >= rem_m[a]) ? rem_m[a] : (POS_W+1)'(vel_n[a]);
            gen_end[a] = (step[a] == rem_m[a]) || (st_q[a] == AX_HALT && vel_n[a] == VEL_ZERO);
            gen_n[a] = dir[a] ? gen_q[a] - step[a][POS_W-1:0] : gen_q[a] + step[a][POS_W-1:0];
            fdiff[a] = gen_n[a] - out_q[a];
            fstep[a] = fdiff[a] >>> smooth_q[a];
            if (fstep[a] == POS_RST && fdiff[a] != POS_RST) begin
                fstep[a] = fdiff[a][POS_W-1] ? POS_NEG_ONE : POS_ONE;
            end
            out_n[a] = out_q[a] + fstep[a];
        end
    end

    // axis state machines, independent per axis
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int a = 0; a < AXES; a++) begin
                st_q[a] <= AX_IDLE;
                tgt_q[a] <= POS_RST;
                gen_q[a] <= POS_RST;
                out_q[a] <= POS_RST;
                vel_q[a] <= VEL_ZERO;
            end
        end else begin
            for (int a = 0; a < AXES; a++) begin
                case (st_q[a])
                    AX_IDLE: begin
                        gen_q[a] <= out_q[a];
                        vel_q[a] <= VEL_ZERO;
                        if (inc_wr[a]) begin
                            tgt_q[a] <= out_q[a] + pos_t'(hwdata);
                            st_q[a] <= AX_RUN;
                        end else if (launch_cmd[a]) begin
                            tgt_q[a] <= abs_mode_q[a] ? abs_q[a] : out_q[a] + rel_q[a];
                            st_q[a] <= AX_RUN;
                        end
                    end
                    AX_RUN, AX_HALT: begin
                        if (inc_wr[a]) tgt_q[a] <= tgt_q[a] + pos_t'(hwdata);
                        if (tick_q) begin
                            vel_q[a] <= vel_n[a];
                            gen_q[a] <= gen_n[a];
                            out_q[a] <= out_n[a];
                        end
                        if (tick_q && gen_end[a] && !inc_wr[a]) begin
                            vel_q[a] <= VEL_ZERO;
                            st_q[a] <= (out_n[a] == gen_n[a]) ? AX_IDLE : AX_SETTLE;
                        end else if (halt_cmd[a] && st_q[a] == AX_RUN) begin
                            st_q[a] <= AX_HALT;
                        end
                    end
                    AX_SETTLE: begin
                        if (inc_wr[a]) begin
                            tgt_q[a] <= tgt_q[a] + pos_t'(hwdata);
                            st_q[a] <= AX_RUN;
                        end else if (tick_q) begin
                            out_q[a] <= out_n[a];
                            if (out_n[a] == gen_q[a]) st_q[a] <= AX_IDLE;
                        end
                    end
                    default: st_q[a] <= AX_IDLE;
                endcase
            end
        end
    end

    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            cmd_position[a] = out_q[a];
            profile_done[a] = (st_q[a] == AX_IDLE);
            in_position_ok[a] = (st_q[a] == AX_IDLE) && inpos_s_q[a];
        end
    end

    property p_hold_ticks;
        @(posedge sys_clk) disable iff (rst)
        !tick_q |=> $stable(cmd_position);
    endproperty
    a_hold_ticks: assert property (p_hold_ticks) else $error("position moved off tick");

    property p_done_after_tick;
        @(posedge sys_clk) disable iff (rst)
        $rose(profile_done[0]) |-> $past(tick_q);
    endproperty
    a_done_after_tick: assert property (p_done_after_tick) else $error("done not on tick");

    property p_launch_run;
        @(posedge sys_clk) disable iff (rst)
        (st_q[0] == AX_IDLE && launch_cmd[0]) |=> st_q[0] == AX_RUN;
    endproperty
    a_launch_run: assert property (p_launch_run) else $error("launch did not start");

    property p_launch_all;
        @(posedge sys_clk) disable iff (rst)
        (cmd_wr && cmd_op == OP_LAUNCH && cmd_mask == '0 && profile_done == '1)
            |=> profile_done == '0;
    endproperty
    a_launch_all: assert property (p_launch_all) else $error("empty mask not all");

    property p_exact_stop;
        @(posedge sys_clk) disable iff (rst)
        (st_q[0] == AX_RUN && tick_q && gen_end[0] && !inc_wr[0]) |=> gen_q[0] == tgt_q[0];
    endproperty
    a_exact_stop: assert property (p_exact_stop) else $error("stopped off target");

    property p_brake_slows;
        @(posedge sys_clk) disable iff (rst)
        (st_q[0] == AX_RUN && tick_q && brake[0] && vel_q[0] > VEL_MIN)
            |=> vel_q[0] < $past(vel_q[0]);
    endproperty
    a_brake_slows: assert property (p_brake_slows) else $error("no early ramp down");

    // halt and increment checks on every axis
    for (genvar g = 0; g < AXES; g++) begin : g_axis_chk
        property p_halt_entry;
            @(posedge sys_clk) disable iff (rst)
            (st_q[g] == AX_RUN && halt_cmd[g] && !tick_q) |=> st_q[g] == AX_HALT;
        endproperty
        a_halt_entry: assert property (p_halt_entry) else $error("halt not taken");

        property p_inc_rest;
            @(posedge sys_clk) disable iff (rst)
            (st_q[g] == AX_IDLE && inc_wr[g])
                |=> st_q[g] == AX_RUN && tgt_q[g] == $past(out_q[g]) + pos_t'($past(hwdata));
        endproperty
        a_inc_rest: assert property (p_inc_rest) else $error("rest increment wrong");

        property p_inc_move;
            @(posedge sys_clk) disable iff (rst)
            (st_q[g] == AX_RUN && inc_wr[g])
                |=> tgt_q[g] == $past(tgt_q[g]) + pos_t'($past(hwdata));
        endproperty
        a_inc_move: assert property (p_inc_move) else $error("moving increment wrong");
    end

    property p_dn_lock;
        @(posedge sys_clk) disable iff (rst)
        (st_q[0] != AX_IDLE && dn_wr[0]) |=> $stable(dn_q[0]);
    endproperty
    a_dn_lock: assert property (p_dn_lock) else $error("ramp-down changed in motion");

    property p_slew_live;
        @(posedge sys_clk) disable iff (rst)
        (st_q[0] == AX_RUN && slew_wr[0]) |=> slew_q[0] == $past(hwdata[VEL_W-1:0]);
    endproperty
    a_slew_live: assert property (p_slew_live) else $error("slew not updated");
endmodule

// ---- tb/settle_model.sv ----
// far-side motor model: reports in position once the command has rested a while
`timescale 1ns/1ps
module settle_model
    import profiler_pkg::*;
#(
    parameter int SETTLE_CYC = 300
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // axis side
    input wire logic [profiler_pkg::AXES-1:0][profiler_pkg::POS_W-1:0] cmd_position,
    output logic [profiler_pkg::AXES-1:0] in_position_pin
);
    logic [AXES-1:0][POS_W-1:0] last_q;
    int quiet_q [AXES];

    always_ff @(posedge sys_clk) begin
        for (int a = 0; a < AXES; a++) begin
            last_q[a] <= cmd_position[a];
            if (rst || cmd_position[a] !== last_q[a]) begin
                quiet_q[a] <= 0;
            end else if (quiet_q[a] < SETTLE_CYC) begin
                quiet_q[a] <= quiet_q[a] + 1;
            end
        end
    end

    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            in_position_pin[a] = (quiet_q[a] >= SETTLE_CYC);
        end
    end
endmodule

// ---- tb/tb_independent_axis_profiler.sv ----
// self-checking bench for the independent axis profiler
`timescale 1ns/1ps
module tb_independent_axis_profiler;
    import profiler_pkg::*;
    logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, sample_tick, prev_tick;
    wire logic hready;
    logic [HADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [DATA_W-1:0] hwdata, hrdata, rd;
    logic [AXES-1:0] in_position_pin, profile_done, in_position_ok;
    logic [AXES-1:0][POS_W-1:0] cmd_position, prev_pos;
    int num_errors, checked, max_step, step;

    assign hready = hreadyout;

    independent_axis_profiler dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .in_position_pin(in_position_pin), .cmd_position(cmd_position),
        .profile_done(profile_done), .in_position_ok(in_position_ok),
        .sample_tick(sample_tick));

    settle_model u_motor (.sys_clk(sys_clk), .rst(rst), .cmd_position(cmd_position),
        .in_position_pin(in_position_pin));

    task automatic results();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            results();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, DATA_ZERO);
        check(rd, exp);
        check(32'(hresp), 32'(HRESP_OKAY));
    endtask

    function automatic logic [31:0] ax(input int a, input logic [4:0] o);
        return {20'h0, AXIS_PAGE, 2'(a), o};
    endfunction

    function automatic logic [31:0] cw(input logic [1:0] op, input logic [3:0] m);
        return {22'h0, op, 4'h0, m};
    endfunction

    task automatic setup(input int a, input logic [31:0] rel, input logic [31:0] slew);
        bus(1'b1, ax(a, REL_OFS), rel);
        bus(1'b1, ax(a, SLEW_OFS), slew);
        bus(1'b1, ax(a, UP_OFS), 32'h2);
        bus(1'b1, ax(a, DN_OFS), 32'h2);
    endtask

    task automatic wait_done(input logic [3:0] m);
        int n;
        n = 0;
        repeat (3) @(posedge sys_clk);
        while ((profile_done & m) !== m && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 20000) begin
            num_errors++;
            results();
        end
    endtask

    always @(posedge sys_clk) begin
        if (rst === 1'b0 && cmd_position !== prev_pos) begin
            check(32'(prev_tick), 32'h1);
            step = $signed(cmd_position[0]) - $signed(prev_pos[0]);
            step = (step < 0) ? -step : step;
            max_step = (step > max_step) ? step : max_step;
        end
        prev_pos <= cmd_position;
        prev_tick <= sample_tick;
    end

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata, prev_tick} = '0;
        hsize = HSIZE_WORD;
        prev_pos = '0;
        {num_errors, checked, max_step} = '0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rchk({20'h0, STATUS_OFS}, 32'h0000000F);
        bus(1'b1, 32'h00000080, 32'h12345678);
        rchk(32'h00000080, DATA_ZERO);
        // trapezoid with live slew change
        setup(0, 32'h64, 32'hA);
        bus(1'b1, {20'h0, CMD_OFS}, cw(OP_LAUNCH, 4'h1));
        bus(1'b1, ax(0, SLEW_OFS), 32'h6);
        bus(1'b1, ax(0, DN_OFS), 32'h5);
        check(32'(profile_done), 32'hE);
        rchk(ax(0, ABS_OFS), 32'h64);
        wait_done(4'h1);
        check(cmd_position[0], 32'h64);
        check(32'(max_step), 32'h6);
        rchk(ax(0, DN_OFS), 32'h2);
        rchk(ax(0, SLEW_OFS), 32'h6);
        rchk(ax(0, UP_OFS), 32'h2);
        rchk(ax(0, REL_OFS), 32'h64);
        // short move right after completion
        max_step = 0;
        setup(0, 32'h14, 32'hA);
        bus(1'b1, {20'h0, CMD_OFS}, cw(OP_LAUNCH, 4'h1));
        @(posedge sys_clk);
        check(32'(profile_done[0]), 32'h0);
        wait_done(4'h1);
        check(cmd_position[0], 32'h78);
        check(32'(max_step > 0 && max_step < 10), 32'h1);
        // empty mask launches every axis
        for (int a = 0; a < AXES; a++) begin
            setup(a, 32'h8, 32'h4);
        end
        bus(1'b1, {20'h0, CMD_OFS}, cw(OP_LAUNCH, 4'h0));
        @(posedge sys_clk);
        check(32'(profile_done), 32'h0);
        wait_done(4'hF);
        for (int a = 1; a < AXES; a++) begin
            check(cmd_position[a], 32'h8);
        end
        check(cmd_position[0], 32'h80);
        // controlled halt in mid-move
        setup(1, 32'h190, 32'hA);
        bus(1'b1, {20'h0, CMD_OFS}, cw(OP_LAUNCH, 4'h2));
        repeat (1250) @(posedge sys_clk);
        bus(1'b1, {20'h0, CMD_OFS}, cw(OP_HALT, 4'h2));
        wait_done(4'h2);
        check(32'($signed(cmd_position[1]) > 8 && $signed(cmd_position[1]) < 408), 32'h1);
        // increment while moving, same direction
        setup(2, 32'h64, 32'h4);
        bus(1'b1, {20'h0, CMD_OFS}, cw(OP_LAUNCH, 4'h4));
        repeat (500) @(posedge sys_clk);
        bus(1'b1, ax(2, INC_OFS), 32'h32);
        wait_done(4'h4);
        check(cmd_position[2], 32'h9E);
        // increment at rest starts a relative move
        bus(1'b1, ax(3, INC_OFS), 32'h1E);
        @(posedge sys_clk);
        check(32'(profile_done[3]), 32'h0);
        wait_done(4'h8);
        check(cmd_position[3], 32'h26);
        rchk(ax(3, REL_OFS), 32'h1E);
        // smoothed move still lands exactly
        bus(1'b1, ax(3, SMOOTH_OFS), 32'h2);
        setup(3, 32'h28, 32'h4);
        bus(1'b1, {20'h0, CMD_OFS}, cw(OP_LAUNCH, 4'h8));
        wait_done(4'h8);
        check(cmd_position[3], 32'h4E);
        for (int n = 0; n < 1000 && in_position_ok !== 4'hF; n++) begin
            @(posedge sys_clk);
        end
        check(32'(in_position_ok), 32'hF);
        rchk({20'h0, STATUS_OFS}, 32'h00000F0F);
        results();
    end
endmodule
